/* logic/twst_cfg.svh */
// constants for the two-wire slave-transmitter status block
//
// Overview of operation
// - own address read acked gives status a8
// - arbitration lost then read-addressed gives b0
// - byte sent and acked gives status b8
// - byte sent and not acked gives c0
// - final byte acked anyway gives c8
// - unaddressed state recognises address only with ack_enable
// - pending start request sent once bus frees
// - flag clear means status f8
// - status f8 needs no software action
// - misplaced start or stop gives status 00
// - bus error sets the interrupt flag
// - recovery releases lines, clears stop, no stop
// - master keeps bus across repeated start
// - own address upper seven, bit zero general-call
// - after final byte master reads all ones
// - status code upper five, prescaler lowest two
`ifndef TWST_CFG_SVH
`define TWST_CFG_SVH

`define TWST_ST_OWN_READ   8'ha8
`define TWST_ST_ARB_READ   8'hb0
`define TWST_ST_TX_ACK     8'hb8
`define TWST_ST_TX_NACK    8'hc0
`define TWST_ST_LAST_ACK   8'hc8
`define TWST_ST_NO_INFO    8'hf8
`define TWST_ST_BUS_ERROR  8'h00
`define TWST_BYTE_BITS     4'h8
`define TWST_IDLE_BYTE     8'hff
`define TWST_CLK_MHZ       20
`define TWST_START_HOLD_NS 4000
`define TWST_FIFO_DEPTH    8

`endif

/* logic/twst_pkg.sv */
// types shared by the slave-transmitter block
`default_nettype none
package twst_pkg;
    typedef enum logic [3:0] {
        S_IDLE,
        S_ADDR,
        S_ADDR_ACK,
        S_WAIT_SW,
        S_TX,
        S_TX_ACK,
        S_BERR,
        S_GEN_START
    } twst_state_t;
endpackage
`default_nettype wire

/* logic/twst_stream_if.sv */
// byte stream carrier between the data fifo and the serial core
`default_nettype none
interface twst_stream_if #(parameter int WIDTH = 8);
    logic             valid;
    logic             ready;
    logic [WIDTH-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

/* logic/twst_fifo.sv */
// flip-flop fifo holding bytes queued for transmission
`default_nettype none
module twst_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // clock and reset
    input  wire logic             ref_clk,
    input  wire logic             rst,
    // filling side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // draining side
    twst_stream_if.src            out
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0]    wr_reg;
    logic [AW-1:0]    rd_reg;
    logic [CW-1:0]    cnt_reg;
    logic             push;
    logic             pop;

    assign in_ready  = (cnt_reg != CW'(DEPTH));
    assign out.valid = (cnt_reg != '0);
    assign out.data  = mem_reg[rd_reg];
    assign push      = in_valid && in_ready;
    assign pop       = out.valid && out.ready;

    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem_reg[wr_reg] <= in_data;
        end
    end

    // pointers wrap by hand so depth need not be a power of two
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            wr_reg  <= '0;
            rd_reg  <= '0;
            cnt_reg <= '0;
        end else begin
            if (push) begin
                wr_reg <= (wr_reg == AW'(DEPTH - 1)) ? '0 : wr_reg + 1'b1;
            end
            if (pop) begin
                rd_reg <= (rd_reg == AW'(DEPTH - 1)) ? '0 : rd_reg + 1'b1;
            end
            if (push && !pop) begin
                cnt_reg <= cnt_reg + 1'b1;
            end else if (pop && !push) begin
                cnt_reg <= cnt_reg - 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

/* logic/twst_slave_tx.sv */
// two-wire slave transmitter with status reporting and bus error recovery
`include "twst_cfg.svh"
`default_nettype none
module twst_slave_tx #(
    parameter int DEPTH         = `TWST_FIFO_DEPTH,
    parameter int START_HOLD_NS = `TWST_START_HOLD_NS
) (
    // clock and reset
    input  wire logic       ref_clk,
    input  wire logic       rst,
    // serial bus, open drain
    input  wire logic       scl_in,
    output logic            scl_out,
    output logic            scl_oe,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe,
    // data register path
    input  wire logic       tx_valid,
    output logic            tx_ready,
    input  wire logic [7:0] tx_data,
    // control register write
    input  wire logic       ctrl_wr,
    input  wire logic       int_flag_clear,
    input  wire logic       ack_enable_wr,
    input  wire logic       start_request_wr,
    input  wire logic       stop_request_wr,
    // configuration
    input  wire logic [7:0] own_address_register,
    input  wire logic [1:0] prescaler,
    input  wire logic       arb_lost_addr,
    // status
    output logic [7:0]      status_register,
    output logic            interrupt_flag,
    output logic            ack_enable,
    output logic            start_request,
    output logic            stop_request,
    output logic            bus_owned,
    output logic            start_sent
);
    localparam int HOLD_CYC = (START_HOLD_NS * `TWST_CLK_MHZ + 999) / 1000;
    localparam int HW       = $clog2(HOLD_CYC + 1);

    twst_stream_if #(.WIDTH(8)) pop_if ();

    twst_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_fifo (
        .ref_clk  (ref_clk),
        .rst      (rst),
        .in_valid (tx_valid),
        .in_ready (tx_ready),
        .in_data  (tx_data),
        .out      (pop_if.src)
    );

    twst_pkg::twst_state_t state_reg;
    logic [3:0]            bit_reg;
    logic [7:0]            shift_reg;
    logic [7:0]            code_reg;
    logic [HW-1:0]         hold_reg;
    logic scl_s1, scl_s2, scl_d;
    logic sda_s1, sda_s2, sda_d;
    logic flag_reg, ack_en_reg, start_reg, stop_reg;
    logic ack_phase_reg, got_ack_reg, last_reg, arb_reg;
    logic busy_reg, owned_reg, start_pend_reg, start_sent_reg;
    logic scl_rise, scl_fall, start_det, stop_det, illegal;
    logic clr, recover, addr_done, tx_done, load_code, in_frame;

    ////////////////////////////////////////////////////////////////////////////
    // pin sampling and bus conditions

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            {scl_s1, scl_s2, scl_d} <= 3'h7;
            {sda_s1, sda_s2, sda_d} <= 3'h7;
        end else begin
            {scl_s1, scl_s2, scl_d} <= {scl_in, scl_s1, scl_s2};
            {sda_s1, sda_s2, sda_d} <= {sda_in, sda_s1, sda_s2};
        end
    end

    assign scl_rise  = scl_s2 && !scl_d;
    assign scl_fall  = !scl_s2 && scl_d;
    assign start_det = scl_s2 && scl_d && sda_d && !sda_s2;
    assign stop_det  = scl_s2 && scl_d && !sda_d && sda_s2;
    assign in_frame  = ((state_reg == twst_pkg::S_ADDR || state_reg == twst_pkg::S_TX)
                        && bit_reg != 4'h0)
                       || state_reg == twst_pkg::S_ADDR_ACK
                       || state_reg == twst_pkg::S_TX_ACK;
    assign illegal   = (start_det || stop_det) && in_frame;

    // upper seven bits address, bit zero general call; read only
    function automatic logic addr_hit(input logic [7:0] b, input logic [7:0] own,
                                      input logic en);
        addr_hit = en && b[0] && ((b[7:1] == own[7:1])
                   || (b[7:1] == 7'h00 && own[0]));
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // control bits

    assign recover   = state_reg == twst_pkg::S_BERR && ctrl_wr && int_flag_clear
                       && stop_request_wr;
    assign clr       = ctrl_wr && int_flag_clear && flag_reg
                       && (state_reg != twst_pkg::S_BERR || stop_request_wr);
    assign addr_done = state_reg == twst_pkg::S_ADDR_ACK && scl_fall && ack_phase_reg;
    assign tx_done   = state_reg == twst_pkg::S_TX_ACK && scl_fall && ack_phase_reg;
    assign load_code = code_reg == `TWST_ST_OWN_READ || code_reg == `TWST_ST_ARB_READ
                       || code_reg == `TWST_ST_TX_ACK;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ack_en_reg <= 1'b0;
            start_reg  <= 1'b0;
            stop_reg   <= 1'b0;
        end else begin
            if (ctrl_wr) begin
                ack_en_reg <= ack_enable_wr;
                start_reg  <= start_request_wr;
            end
            if (recover) begin
                stop_reg <= 1'b0;
            end else if (ctrl_wr) begin
                stop_reg <= stop_request_wr;
            end
        end
    end

    // a setting event wins over a clear in the same cycle
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            flag_reg <= 1'b0;
            code_reg <= `TWST_ST_NO_INFO;
        end else if (illegal) begin
            flag_reg <= 1'b1;
            code_reg <= `TWST_ST_BUS_ERROR;
        end else if (addr_done) begin
            flag_reg <= 1'b1;
            code_reg <= arb_reg ? `TWST_ST_ARB_READ : `TWST_ST_OWN_READ;
        end else if (tx_done) begin
            flag_reg <= 1'b1;
            code_reg <= !got_ack_reg ? `TWST_ST_TX_NACK :
                        last_reg ? `TWST_ST_LAST_ACK : `TWST_ST_TX_ACK;
        end else if (clr) begin
            flag_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // serial state machine

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_reg     <= twst_pkg::S_IDLE;
            bit_reg       <= 4'h0;
            shift_reg     <= `TWST_IDLE_BYTE;
            ack_phase_reg <= 1'b0;
            got_ack_reg   <= 1'b0;
            last_reg      <= 1'b0;
            hold_reg      <= '0;
        end else if (illegal) begin
            state_reg <= twst_pkg::S_BERR;
        end else if (start_det && state_reg != twst_pkg::S_GEN_START
                     && state_reg != twst_pkg::S_BERR) begin
            state_reg <= twst_pkg::S_ADDR;
            bit_reg   <= 4'h0;
        end else if (stop_det && state_reg != twst_pkg::S_GEN_START
                     && state_reg != twst_pkg::S_BERR) begin
            state_reg <= twst_pkg::S_IDLE;
        end else begin
            case (state_reg)
                twst_pkg::S_IDLE: begin
                    if (start_pend_reg && !busy_reg) begin
                        state_reg <= twst_pkg::S_GEN_START;
                        hold_reg  <= '0;
                    end
                end
                twst_pkg::S_ADDR: begin
                    if (scl_rise) begin
                        shift_reg <= {shift_reg[6:0], sda_s2};
                        bit_reg   <= bit_reg + 4'h1;
                    end else if (scl_fall && bit_reg == `TWST_BYTE_BITS) begin
                        ack_phase_reg <= 1'b0;
                        state_reg     <= addr_hit(shift_reg, own_address_register, ack_en_reg)
                                         ? twst_pkg::S_ADDR_ACK : twst_pkg::S_IDLE;
                    end
                end
                twst_pkg::S_ADDR_ACK: begin
                    if (scl_rise) begin
                        ack_phase_reg <= 1'b1;
                    end else if (addr_done) begin
                        state_reg <= twst_pkg::S_WAIT_SW;
                    end
                end
                twst_pkg::S_WAIT_SW: begin
                    if (clr && load_code) begin
                        // an empty queue sends ones rather than stalling the bus
                        shift_reg <= pop_if.valid ? pop_if.data : `TWST_IDLE_BYTE;
                        last_reg  <= !ack_enable_wr;
                        bit_reg   <= 4'h0;
                        state_reg <= twst_pkg::S_TX;
                    end else if (clr) begin
                        state_reg <= twst_pkg::S_IDLE;
                    end
                end
                twst_pkg::S_TX: begin
                    if (scl_rise) begin
                        bit_reg <= bit_reg + 4'h1;
                    end else if (scl_fall && bit_reg == `TWST_BYTE_BITS) begin
                        ack_phase_reg <= 1'b0;
                        state_reg     <= twst_pkg::S_TX_ACK;
                    end else if (scl_fall) begin
                        shift_reg <= {shift_reg[6:0], 1'b1};
                    end
                end
                twst_pkg::S_TX_ACK: begin
                    if (scl_rise) begin
                        got_ack_reg   <= !sda_s2;
                        ack_phase_reg <= 1'b1;
                    end else if (tx_done) begin
                        state_reg <= twst_pkg::S_WAIT_SW;
                    end
                end
                twst_pkg::S_BERR: begin
                    if (recover) begin
                        state_reg <= twst_pkg::S_IDLE;
                    end
                end
                twst_pkg::S_GEN_START: begin
                    if (hold_reg == HW'(HOLD_CYC - 1)) begin
                        state_reg <= twst_pkg::S_ADDR;
                        bit_reg   <= 4'h0;
                    end else begin
                        hold_reg <= hold_reg + 1'b1;
                    end
                end
                default: begin
                    state_reg <= twst_pkg::S_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // bus ownership, arbitration memory, start requests

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            busy_reg <= 1'b0;
        end else if (start_det) begin
            busy_reg <= 1'b1;
        end else if (stop_det || recover) begin
            busy_reg <= 1'b0;
        end
    end

    // a repeated start does not end ownership, only a stop or bus error recovery does
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            owned_reg <= 1'b0;
        end else if (start_sent_reg) begin
            owned_reg <= 1'b1;
        end else if (stop_det || recover) begin
            owned_reg <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            arb_reg <= 1'b0;
        end else if (arb_lost_addr) begin
            arb_reg <= 1'b1;
        end else if (addr_done || stop_det) begin
            arb_reg <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            start_pend_reg <= 1'b0;
            start_sent_reg <= 1'b0;
        end else begin
            start_sent_reg <= state_reg == twst_pkg::S_GEN_START
                              && hold_reg == HW'(HOLD_CYC - 1) && !illegal;
            if (state_reg == twst_pkg::S_WAIT_SW && clr && !load_code && start_request_wr) begin
                start_pend_reg <= 1'b1;
            end else if (state_reg == twst_pkg::S_GEN_START) begin
                start_pend_reg <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    assign pop_if.ready    = state_reg == twst_pkg::S_WAIT_SW && clr && load_code;
    assign scl_out         = 1'b0;
    assign sda_out         = 1'b0;
    assign scl_oe          = state_reg == twst_pkg::S_WAIT_SW;
    assign sda_oe          = state_reg == twst_pkg::S_ADDR_ACK
                             || state_reg == twst_pkg::S_GEN_START
                             || (state_reg == twst_pkg::S_TX && !shift_reg[7]);
    assign status_register = {flag_reg ? code_reg[7:3] : 5'(`TWST_ST_NO_INFO >> 3),
                              1'b0, prescaler};
    assign interrupt_flag  = flag_reg;
    assign ack_enable      = ack_en_reg;
    assign start_request   = start_reg;
    assign stop_request    = stop_reg;
    assign bus_owned       = owned_reg;
    assign start_sent      = start_sent_reg;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    chk_status_no_info: assert property (
        !flag_reg |-> status_register[7:3] == 5'h1f)
        else $error("status not f8 while flag clear");
    chk_scl_held_low: assert property (
        flag_reg && state_reg != twst_pkg::S_BERR |-> scl_oe && !scl_out)
        else $error("scl released while flag set");
    chk_bus_error_flag: assert property (
        illegal |=> flag_reg && status_register[7:3] == 5'h00 && !scl_oe)
        else $error("bus error not reported");
    chk_error_recover: assert property (
        recover |=> state_reg == twst_pkg::S_IDLE && !stop_reg && !flag_reg
                    && !sda_oe && !scl_oe)
        else $error("bus error recovery incomplete");
    chk_own_read_code: assert property (
        addr_done && !arb_reg && !illegal |=> status_register[7:3] == 5'h15 ##0 scl_oe)
        else $error("own read address status wrong");
    chk_arb_read_code: assert property (
        addr_done && arb_reg && !illegal |=> status_register[7:3] == 5'h16)
        else $error("arbitration lost read status wrong");
    chk_tx_ack_codes: assert property (
        tx_done && got_ack_reg && !illegal
        |=> status_register[7:3] == ($past(last_reg) ? 5'h19 : 5'h17))
        else $error("acked byte status wrong");
    chk_tx_nack_code: assert property (
        tx_done && !got_ack_reg && !illegal |=> status_register[7:3] == 5'h18)
        else $error("not acked byte status wrong");
    chk_final_release: assert property (
        state_reg == twst_pkg::S_WAIT_SW && clr && !load_code |=> !sda_oe [*2])
        else $error("sda driven after final byte");
    chk_start_when_free: assert property (
        state_reg == twst_pkg::S_IDLE && start_pend_reg && !busy_reg && !start_det
        && !stop_det |=> state_reg == twst_pkg::S_GEN_START ##0 sda_oe)
        else $error("pending start not issued on free bus");
    chk_owned_restart: assert property (
        owned_reg && start_det && !stop_det |=> owned_reg)
        else $error("ownership lost on repeated start");
    chk_ignore_unacked: assert property (
        state_reg == twst_pkg::S_ADDR && scl_fall && bit_reg == 4'h8 && !ack_en_reg
        && !start_det && !stop_det |=> state_reg == twst_pkg::S_IDLE)
        else $error("address recognised with ack disabled");

    cov_own_read: cover property (addr_done && !arb_reg);
    cov_last_acked: cover property (tx_done && got_ack_reg && last_reg);
    cov_bus_error: cover property (recover);
    cov_start_sent: cover property (start_sent_reg);
endmodule
`default_nettype wire

/* sim/twst_bus_master.sv */
// bus master model driving open-drain scl and sda at a 400 ns bit period
`default_nettype none
module twst_bus_master (
    // lines as seen on the bus
    input  wire logic scl,
    input  wire logic sda,
    // pull-low enables
    output logic      scl_drv,
    output logic      sda_drv
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        scl_drv = 1'b0;
        sda_drv = 1'b0;
    end
    // slave may stretch the low phase, so wait for the real high level
    task automatic put(input logic b, output logic r);
        sda_drv = !b;
        #100;
        scl_drv = 1'b0;
        while (!scl) #50;
        #100;
        r = sda;
        #100;
        scl_drv = 1'b1;
        #100;
    endtask
    task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q,
                        output logic r);
        for (int i = 7; i >= 0; i--) put(d[i], q[i]);
        put(a, r);
    endtask
    // scl low first so a repeated start never looks like a stop
    task automatic start();
        scl_drv = 1'b1;
        #100;
        sda_drv = 1'b0;
        scl_drv = 1'b0;
        while (!scl) #50;
        #100;
        sda_drv = 1'b1;
        #100;
        scl_drv = 1'b1;
        #100;
    endtask
    task automatic stop();
        sda_drv = 1'b1;
        #100;
        scl_drv = 1'b0;
        while (!scl) #50;
        #100;
        sda_drv = 1'b0;
        #100;
    endtask
    task automatic hold();
        sda_drv = 1'b1;
    endtask
    // master takes the clock low after a start it did not make itself
    task automatic low();
        scl_drv = 1'b1;
        #100;
    endtask
endmodule
`default_nettype wire

/* sim/tb_top.sv */
// self-checking bench for the slave-transmitter block
`include "twst_cfg.svh"
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [1:0] PRE = 2'h2;
    logic ref_clk = 1'b0, rst = 1'b1, tx_valid = 1'b0, ctrl_wr = 1'b0;
    logic int_flag_clear = 1'b0, ack_enable_wr = 1'b0, start_request_wr = 1'b0;
    logic stop_request_wr = 1'b0, arb_lost_addr = 1'b0;
    logic [7:0] tx_data = 8'h00, status_register, q;
    logic [7:0] own_addr = 8'h53;
    logic scl_oe, sda_oe, m_scl, m_sda, tx_ready, interrupt_flag, r;
    logic ack_enable, start_request, stop_request, bus_owned, start_sent;
    wire logic scl = !(scl_oe | m_scl);
    wire logic sda = !(sda_oe | m_sda);
    int n_mismatch = 0, checked = 0, cyc = 0;
    always #25 ref_clk = ~ref_clk;
    twst_slave_tx #(.START_HOLD_NS(200)) uut (.ref_clk(ref_clk), .rst(rst),
        .scl_in(scl), .scl_out(), .scl_oe(scl_oe), .sda_in(sda), .sda_out(),
        .sda_oe(sda_oe), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
        .ctrl_wr(ctrl_wr), .int_flag_clear(int_flag_clear), .ack_enable_wr(ack_enable_wr),
        .start_request_wr(start_request_wr), .stop_request_wr(stop_request_wr),
        .own_address_register(own_addr), .prescaler(PRE), .arb_lost_addr(arb_lost_addr),
        .status_register(status_register), .interrupt_flag(interrupt_flag),
        .ack_enable(ack_enable), .start_request(start_request),
        .stop_request(stop_request), .bus_owned(bus_owned), .start_sent(start_sent));
    twst_bus_master m (.scl(scl), .sda(sda), .scl_drv(m_scl), .sda_drv(m_sda));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            finish_test();
        end
    end
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic ctl(input logic c, input logic a, input logic s, input logic p);
        @(posedge ref_clk);
        ctrl_wr <= 1'b1;
        int_flag_clear <= c;
        ack_enable_wr <= a;
        start_request_wr <= s;
        stop_request_wr <= p;
        @(posedge ref_clk);
        ctrl_wr <= 1'b0;
        @(negedge ref_clk);
    endtask
    task automatic wflag(input logic [7:0] code);
        for (int k = 0; k < 400 && interrupt_flag !== 1'b1; k++) @(negedge ref_clk);
        chk("status", {code[7:3], 1'b0, PRE}, status_register);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic s_fill();
        @(negedge ref_clk);
        chk("idle status", {5'h1f, 1'b0, PRE}, status_register);
        for (int i = 0; i < 8; i++) begin
            @(posedge ref_clk);
            tx_valid <= 1'b1;
            tx_data <= 8'ha0 + 8'(i);
        end
        @(posedge ref_clk);
        tx_valid <= 1'b0;
        @(negedge ref_clk);
        chk("full", 8'h0, 8'(tx_ready));
    endtask
    task automatic s_read();
        ctl(1'b0, 1'b1, 1'b0, 1'b0);
        m.start();
        m.xfer(8'h52, 1'b1, q, r);
        m.start();
        m.xfer(8'h53, 1'b1, q, r);
        wflag(`TWST_ST_OWN_READ);
        repeat (20) @(negedge ref_clk);
        chk("stretch", 8'h1, 8'(scl_oe));
        ctl(1'b1, 1'b1, 1'b0, 1'b0);
        m.xfer(8'hff, 1'b0, q, r);
        chk("byte0", 8'ha0, q);
        wflag(`TWST_ST_TX_ACK);
        ctl(1'b1, 1'b0, 1'b0, 1'b0);
        m.xfer(8'hff, 1'b0, q, r);
        chk("byte1", 8'ha1, q);
        wflag(`TWST_ST_LAST_ACK);
        ctl(1'b1, 1'b1, 1'b0, 1'b0);
        m.xfer(8'hff, 1'b1, q, r);
        chk("after last", `TWST_IDLE_BYTE, q);
        m.stop();
    endtask
    task automatic s_arb();
        @(posedge ref_clk);
        arb_lost_addr <= 1'b1;
        @(posedge ref_clk);
        arb_lost_addr <= 1'b0;
        m.start();
        m.xfer(8'h53, 1'b1, q, r);
        wflag(`TWST_ST_ARB_READ);
        ctl(1'b1, 1'b1, 1'b0, 1'b0);
        m.xfer(8'hff, 1'b1, q, r);
        chk("byte2", 8'ha2, q);
        wflag(`TWST_ST_TX_NACK);
        ctl(1'b1, 1'b1, 1'b1, 1'b0);
        chk("start bit", 8'h1, 8'(start_request));
        m.stop();
        for (int k = 0; k < 300 && sda_oe !== 1'b1; k++) @(negedge ref_clk);
        m.hold();
        for (int k = 0; k < 300 && start_sent !== 1'b1; k++) @(negedge ref_clk);
        chk("start sent", 8'h1, 8'(start_sent));
        ctl(1'b0, 1'b1, 1'b0, 1'b0);
        m.low();
        m.xfer(8'h52, 1'b1, q, r);
        m.start();
        chk("owned", 8'h1, 8'(bus_owned));
        m.xfer(8'h52, 1'b1, q, r);
        m.stop();
        repeat (8) @(negedge ref_clk);
        chk("released", 8'h0, 8'(bus_owned));
    endtask
    task automatic s_gc();
        ctl(1'b0, 1'b0, 1'b0, 1'b0);
        m.start();
        m.xfer(8'h53, 1'b1, q, r);
        chk("no ack", 8'h1, 8'(r));
        m.stop();
        chk("no flag", 8'h0, 8'(interrupt_flag));
        ctl(1'b0, 1'b1, 1'b0, 1'b0);
        @(posedge ref_clk);
        own_addr <= 8'h52;
        m.start();
        m.xfer(8'h01, 1'b1, q, r);
        chk("gc off", 8'h1, 8'(r));
        m.stop();
        @(posedge ref_clk);
        own_addr <= 8'h53;
        m.start();
        m.xfer(8'h01, 1'b1, q, r);
        wflag(`TWST_ST_OWN_READ);
        for (int i = 3; i < 8; i++) begin
            ctl(1'b1, i < 7, 1'b0, 1'b0);
            m.xfer(8'hff, i == 7, q, r);
            chk("drain", 8'ha0 + 8'(i), q);
            wflag(i < 7 ? `TWST_ST_TX_ACK : `TWST_ST_TX_NACK);
        end
        ctl(1'b1, 1'b1, 1'b0, 1'b0);
        m.stop();
        chk("empty", 8'h1, 8'(tx_ready));
    endtask
    task automatic s_err();
        m.start();
        m.put(1'b1, r);
        m.put(1'b0, r);
        m.put(1'b1, r);
        m.stop();
        wflag(`TWST_ST_BUS_ERROR);
        ctl(1'b1, 1'b1, 1'b0, 1'b0);
        chk("clear refused", 8'h1, 8'(interrupt_flag));
        ctl(1'b1, 1'b1, 1'b0, 1'b1);
        chk("recovered", 8'h0, 8'(interrupt_flag));
        chk("stop bit", 8'h0, 8'(stop_request));
        chk("ack kept", 8'h1, 8'(ack_enable));
        chk("lines", 8'h0, 8'({scl_oe, sda_oe}));
    endtask
    initial begin
        repeat (4) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (4) @(posedge ref_clk);
        s_fill();
        s_read();
        s_arb();
        s_gc();
        s_err();
        finish_test();
    end
endmodule
`default_nettype wire
